// File: plcc_ctrl.sv
// single-wire pulse-count control of sink currents and pump mode
//
// How it works
// - rising edges on the enable/set line step the state counter
// - the counted state is latched after the line stays high for the latch timeout
// - the counter holds one of sixteen states, each a current setting
// - states 1 to 4 give both groups 20, 14, 10, 7 mA
// - states 5-8 drive main only, states 9-12 drive sub only
// - states 13 to 16 give both groups dim levels and dim mode
// - main group of four sinks and sub group of two, set independently
// - first edge enables the device at the 20 mA setting
// - edges up to 1 MHz; sink settings change only at the first edge, when a value latches, or at shutdown
// - device shuts down after the line stays low for the off timeout
// - settings hold unchanged while the line stays high after a latch
// - shutdown turns sinks off and clears the stored state to zero
// - a burst of pulses during soft-start is counted in full
// - pump enabled at first edge, full capacity after soft-start time
// - dropout in load-switch mode turns the pump on in 1.5x
// - dropout again in 1.5x moves the pump to 2x
// - an unused sink left open forces 2x pump mode
`timescale 1ns/1ps
module plcc_ctrl #(
  parameter int unsigned LATCH_CYCLES = plcc_pkg::LATCH_TIMEOUT_CYC,
  parameter int unsigned OFF_CYCLES = plcc_pkg::OFF_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // control line from the host
  input wire logic enSet,
  // analog sensing
  input wire logic nearDropout,
  input wire logic unusedSinkOpen,
  // status
  output logic deviceEnable,
  output logic [plcc_pkg::STATE_W-1:0] latchedState,
  // sink groups and pump
  output plcc_pkg::plcc_sink_cfg_t sinkCfg,
  output plcc_pkg::plcc_pump_t pumpMode,
  output logic pumpFullCapacity
);

  plcc_pkg::plcc_ctrl_st_t st_q;
  plcc_pkg::plcc_ctrl_st_t st_d;
  plcc_pkg::plcc_sink_cfg_t nextCfg;
  logic riseEdge;
  logic latchExpired;
  logic offExpired;
  logic softExpired;

  // line is synchronous to sys_clk, so a single stage finds the edge
  assign riseEdge = enSet && !st_q.enPrev;

  plcc_timer #(
    .COUNT(LATCH_CYCLES)
  ) u_latch_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(enSet && st_q.enabled),
    .restart(riseEdge),
    .expired(latchExpired)
  );

  plcc_timer #(
    .COUNT(OFF_CYCLES)
  ) u_off_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(!enSet && st_q.enabled),
    .restart(1'b0),
    .expired(offExpired)
  );

  plcc_timer #(
    .COUNT(plcc_pkg::SOFT_START_CYC)
  ) u_soft_timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .run(st_q.enabled),
    .restart(1'b0),
    .expired(softExpired)
  );

  // sinks follow the registered state one cycle later; decoding the next
  // state instead would close a loop through st_d
  plcc_level_decode u_decode (
    .state(st_q.data),
    .cfg(nextCfg)
  );

  always_comb begin
    st_d = st_q;
    st_d.enPrev = enSet;
    if (st_q.enabled && offExpired) begin
      // shutdown wins; an edge this cycle starts a fresh enable next cycle only if the line is still high
      st_d.enabled = 1'b0;
      st_d.latched = 1'b0;
      st_d.count = plcc_pkg::STATE_NONE;
      st_d.data = plcc_pkg::STATE_NONE;
      st_d.enPrev = 1'b0;
    end else if (riseEdge && !st_q.enabled) begin
      // first edge applies 20 mA at once, before any latch
      st_d.enabled = 1'b1;
      st_d.latched = 1'b0;
      st_d.count = plcc_pkg::STATE_FIRST;
      st_d.data = plcc_pkg::STATE_FIRST;
    end else if (riseEdge) begin
      st_d.latched = 1'b0;
      if (st_q.latched || st_q.count == plcc_pkg::STATE_LAST) begin
        st_d.count = plcc_pkg::STATE_FIRST;
      end else begin
        st_d.count = st_q.count + plcc_pkg::STATE_STEP;
      end
    end else if (st_q.enabled && !st_q.latched && latchExpired) begin
      // outputs follow latched values and the first-edge setting, never a later count in flight
      st_d.latched = 1'b1;
      st_d.data = st_q.count;
    end
    st_d.cfg = nextCfg;
    st_d.pumpFull = st_q.enabled && softExpired;
    // pump mode: load switch first, stepping up on dropout
    if (!st_d.enabled) begin
      st_d.pump = plcc_pkg::PUMP_OFF;
    end else if (unusedSinkOpen) begin
      st_d.pump = plcc_pkg::PUMP_2X;
    end else begin
      unique case (st_q.pump)
        plcc_pkg::PUMP_OFF: begin
          st_d.pump = plcc_pkg::PUMP_1X;
        end
        plcc_pkg::PUMP_1X: begin
          if (nearDropout) begin
            st_d.pump = plcc_pkg::PUMP_1P5X;
          end
        end
        plcc_pkg::PUMP_1P5X: begin
          if (nearDropout) begin
            st_d.pump = plcc_pkg::PUMP_2X;
          end
        end
        plcc_pkg::PUMP_2X: begin
          st_d.pump = plcc_pkg::PUMP_2X;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign deviceEnable = st_q.enabled;
  assign latchedState = st_q.data;
  assign sinkCfg = st_q.cfg;
  assign pumpMode = st_q.pump;
  assign pumpFullCapacity = st_q.pumpFull;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_count_step: assert property (
    riseEdge && st_q.enabled && !st_q.latched && !offExpired
      && st_q.count < plcc_pkg::STATE_LAST
      |=> st_q.count == $past(st_q.count) + plcc_pkg::STATE_STEP)
    else $error("edge did not advance the count");

  chk_latch_value: assert property (
    $rose(st_q.latched) |-> st_q.data == st_q.count && $past(latchExpired))
    else $error("latched value differs from count or latched early");

  chk_state_range: assert property (
    st_q.enabled |-> st_q.count >= plcc_pkg::STATE_FIRST
      && st_q.count <= plcc_pkg::STATE_LAST)
    else $error("count outside sixteen states");

  chk_both_full: assert property (
    st_q.data == plcc_pkg::STATE_FIRST |=> sinkCfg.mainLevel == plcc_pkg::LVL_20MA
      && sinkCfg.subLevel == plcc_pkg::LVL_20MA)
    else $error("state one not 20 mA on both groups");

  chk_main_only: assert property (
    st_q.data == plcc_pkg::STATE_MAIN_ONLY |=> sinkCfg.subLevel == plcc_pkg::LVL_OFF
      && sinkCfg.mainLevel == plcc_pkg::LVL_20MA)
    else $error("state five not main only");

  chk_sub_only: assert property (
    st_q.data == plcc_pkg::STATE_SUB_ONLY |=> sinkCfg.mainLevel == plcc_pkg::LVL_OFF
      && sinkCfg.subLevel == plcc_pkg::LVL_20MA)
    else $error("state nine not sub only");

  chk_dim_levels: assert property (
    st_q.data >= plcc_pkg::STATE_DIM_FIRST |=> sinkCfg.dimMode
      && sinkCfg.mainLevel <= plcc_pkg::LVL_2MA && sinkCfg.mainLevel != plcc_pkg::LVL_OFF)
    else $error("dim states not at low levels");

  chk_first_edge: assert property (
    riseEdge && !st_q.enabled |=> st_q.enabled
      && st_q.data == plcc_pkg::STATE_FIRST ##1 sinkCfg.mainLevel == plcc_pkg::LVL_20MA)
    else $error("first edge did not enable at 20 mA");

  chk_no_midburst: assert property (
    st_q.enabled && riseEdge && $past(st_q.enabled) && !offExpired |=> $stable(st_q.data))
    else $error("counted edge reached the outputs");

  chk_off_shutdown: assert property (
    st_q.enabled && offExpired |=> !st_q.enabled ##1 sinkCfg.mainLevel == plcc_pkg::LVL_OFF
      && sinkCfg.subLevel == plcc_pkg::LVL_OFF)
    else $error("off timeout did not shut down");

  chk_hold_high: assert property (
    enSet && $past(enSet) && st_q.latched |=> $stable(st_q.data))
    else $error("setting moved while line held high");

  chk_data_cleared: assert property (
    !st_q.enabled |-> st_q.data == plcc_pkg::STATE_NONE)
    else $error("data not cleared in shutdown");

  chk_soft_wait: assert property (
    $rose(st_q.enabled) |-> !pumpFullCapacity [*8])
    else $error("full capacity before soft-start");

  chk_pump_1p5: assert property (
    st_q.enabled && pumpMode == plcc_pkg::PUMP_1X && nearDropout && !unusedSinkOpen
      && !offExpired |=> pumpMode == plcc_pkg::PUMP_1P5X)
    else $error("dropout did not start 1.5x");

  chk_pump_2x: assert property (
    st_q.enabled && pumpMode == plcc_pkg::PUMP_1P5X && nearDropout && !offExpired
      |=> pumpMode == plcc_pkg::PUMP_2X)
    else $error("dropout in 1.5x did not move to 2x");

  chk_open_sink: assert property (
    st_q.enabled && unusedSinkOpen && !offExpired |=> pumpMode == plcc_pkg::PUMP_2X)
    else $error("open sink did not force 2x");

  chk_restart: assert property (
    riseEdge && st_q.enabled && st_q.latched && !offExpired
      |=> st_q.count == plcc_pkg::STATE_FIRST)
    else $error("edge after latch did not restart");

  chk_wrap: assert property (
    riseEdge && st_q.enabled && st_q.count == plcc_pkg::STATE_LAST && !offExpired
      |=> st_q.count == plcc_pkg::STATE_FIRST)
    else $error("count did not wrap");

  chk_enable_pump: assert property (
    $rose(st_q.enabled) |-> pumpMode != plcc_pkg::PUMP_OFF)
    else $error("pump not started with enable");

  chk_pump_off: assert property (
    !st_q.enabled |-> pumpMode == plcc_pkg::PUMP_OFF)
    else $error("pump running in shutdown");

  chk_full_off: assert property (
    !st_q.enabled && !$past(st_q.enabled) |-> !pumpFullCapacity)
    else $error("full capacity flag left up in shutdown");

  chk_full_time: assert property (
    $rose(pumpFullCapacity) |-> $past(softExpired) && $past(st_q.enabled))
    else $error("full capacity without soft-start time");

  chk_dim_flag: assert property (
    st_q.data < plcc_pkg::STATE_DIM_FIRST |=> !sinkCfg.dimMode)
    else $error("dim mode outside dim states");

  chk_off_sinks: assert property (
    !st_q.enabled && !$past(st_q.enabled) |-> sinkCfg.mainLevel == plcc_pkg::LVL_OFF
      && sinkCfg.subLevel == plcc_pkg::LVL_OFF)
    else $error("sinks on in shutdown");

  chk_main_range: assert property (
    st_q.data >= plcc_pkg::STATE_MAIN_ONLY && st_q.data < plcc_pkg::STATE_SUB_ONLY
      |=> sinkCfg.subLevel == plcc_pkg::LVL_OFF && sinkCfg.mainLevel != plcc_pkg::LVL_OFF)
    else $error("main-only states touched the sub group");

  chk_sub_range: assert property (
    st_q.data >= plcc_pkg::STATE_SUB_ONLY && st_q.data < plcc_pkg::STATE_DIM_FIRST
      |=> sinkCfg.mainLevel == plcc_pkg::LVL_OFF && sinkCfg.subLevel != plcc_pkg::LVL_OFF)
    else $error("sub-only states touched the main group");

  chk_both_range: assert property (
    st_q.data >= plcc_pkg::STATE_FIRST && st_q.data < plcc_pkg::STATE_MAIN_ONLY
      |=> sinkCfg.mainLevel == sinkCfg.subLevel && sinkCfg.mainLevel >= plcc_pkg::LVL_7MA)
    else $error("shared states not equal and high on both groups");

  chk_dim_equal: assert property (
    st_q.data >= plcc_pkg::STATE_DIM_FIRST |=> sinkCfg.mainLevel == sinkCfg.subLevel)
    else $error("dim states differ between groups");

  chk_latch_clear: assert property (
    riseEdge |=> !st_q.latched)
    else $error("edge did not reopen the count");

  chk_latch_idle: assert property (
    st_q.enabled && !riseEdge && !latchExpired && !offExpired |=> $stable(st_q.data))
    else $error("setting moved without a latch");

  chk_first_count: assert property (
    riseEdge && !st_q.enabled |=> st_q.count == plcc_pkg::STATE_FIRST && !st_q.latched)
    else $error("enable edge did not start the count at one");

  chk_pump_stay2x: assert property (
    st_q.enabled && pumpMode == plcc_pkg::PUMP_2X && !offExpired
      |=> pumpMode == plcc_pkg::PUMP_2X)
    else $error("pump left 2x while enabled");

  chk_pump_calm: assert property (
    st_q.enabled && pumpMode == plcc_pkg::PUMP_1X && !nearDropout && !unusedSinkOpen
      && !offExpired |=> pumpMode == plcc_pkg::PUMP_1X)
    else $error("pump left load switch without dropout");

  chk_enable_edge: assert property (
    $rose(st_q.enabled) |-> $past(riseEdge))
    else $error("enabled without a rising edge");

  chk_off_cause: assert property (
    $fell(st_q.enabled) |-> $past(offExpired))
    else $error("shut down before the off timeout");

  chk_count_clear: assert property (
    st_q.enabled && offExpired |=> st_q.count == plcc_pkg::STATE_NONE && !st_q.latched)
    else $error("shutdown kept the count");

  chk_cfg_hold: assert property (
    enSet && $past(enSet) && st_q.latched && $past(st_q.latched) |=> $stable(sinkCfg))
    else $error("sink levels moved while line held high");

  chk_count_hold: assert property (
    st_q.enabled && !riseEdge && !offExpired |=> $stable(st_q.count))
    else $error("count moved without an edge");

  cov_first_enable: cover property (riseEdge && !st_q.enabled);
  cov_latch: cover property ($rose(st_q.latched));
  cov_dim: cover property (sinkCfg.dimMode);
  cov_shutdown: cover property ($fell(st_q.enabled));
  cov_pump_2x: cover property (pumpMode == plcc_pkg::PUMP_2X);

endmodule : plcc_ctrl

// File: plcc_host_model.sv
// host controller model that drives the enable/set line
`timescale 1ns/1ps
module plcc_host_model (
  // clock
  input wire logic sys_clk,
  // control line
  output logic enSet
);
  // push-pull output, so the line is never left floating
  initial enSet = 1'b0;

  // n pulses, each lo cycles low then hi cycles high; ends with the line held high
  task automatic pulses(input int n, input int hi, input int lo);
    for (int k = 0; k < n; k++) begin
      @(posedge sys_clk) enSet <= 1'b0;
      repeat (lo - 1) @(posedge sys_clk);
      @(posedge sys_clk) enSet <= 1'b1;
      repeat (hi - 1) @(posedge sys_clk);
    end
  endtask : pulses

  // release the setting by pulling the line low
  task automatic drop();
    @(posedge sys_clk) enSet <= 1'b0;
  endtask : drop
endmodule : plcc_host_model

// File: plcc_level_decode.sv
// maps a counter state 1..16 onto main and sub sink group levels
`timescale 1ns/1ps
module plcc_level_decode (
  // state in
  input wire logic [plcc_pkg::STATE_W-1:0] state,
  // setting out
  output plcc_pkg::plcc_sink_cfg_t cfg
);

  logic [plcc_pkg::STATE_W-1:0] idx;
  logic [1:0] step;
  logic [1:0] grp;
  plcc_pkg::plcc_level_t hiLvl;
  plcc_pkg::plcc_level_t dimLvl;

  assign idx = state - plcc_pkg::STATE_STEP;
  assign step = idx[plcc_pkg::STEP_LSB +: 2];
  assign grp = idx[plcc_pkg::GROUP_LSB +: 2];

  always_comb begin
    unique case (step)
      2'h0: begin
        hiLvl = plcc_pkg::LVL_20MA;
        dimLvl = plcc_pkg::LVL_0MA05;
      end
      2'h1: begin
        hiLvl = plcc_pkg::LVL_14MA;
        dimLvl = plcc_pkg::LVL_0MA5;
      end
      2'h2: begin
        hiLvl = plcc_pkg::LVL_10MA;
        dimLvl = plcc_pkg::LVL_1MA;
      end
      2'h3: begin
        hiLvl = plcc_pkg::LVL_7MA;
        dimLvl = plcc_pkg::LVL_2MA;
      end
    endcase
  end

  always_comb begin
    cfg.mainLevel = plcc_pkg::LVL_OFF;
    cfg.subLevel = plcc_pkg::LVL_OFF;
    cfg.dimMode = 1'b0;
    // state zero means shut down: all sinks off
    if (state != plcc_pkg::STATE_NONE) begin
      unique case (grp)
        plcc_pkg::GROUP_BOTH: begin
          cfg.mainLevel = hiLvl;
          cfg.subLevel = hiLvl;
        end
        plcc_pkg::GROUP_MAIN: begin
          cfg.mainLevel = hiLvl;
        end
        plcc_pkg::GROUP_SUB: begin
          cfg.subLevel = hiLvl;
        end
        plcc_pkg::GROUP_DIM: begin
          cfg.mainLevel = dimLvl;
          cfg.subLevel = dimLvl;
          cfg.dimMode = 1'b1;
        end
      endcase
    end
  end

endmodule : plcc_level_decode

// File: plcc_pkg.sv
// constants, types and state carriers for the pulse-count led current controller
package plcc_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int LATCH_TIMEOUT_US = 500;
  localparam int OFF_TIMEOUT_US = 500;
  localparam int SOFT_START_US = 100;
  localparam int NS_PER_US = 1000;
  // all times round down to whole cycles
  localparam int LATCH_TIMEOUT_CYC = (LATCH_TIMEOUT_US * NS_PER_US) / CLK_PERIOD_NS;
  localparam int OFF_TIMEOUT_CYC = (OFF_TIMEOUT_US * NS_PER_US) / CLK_PERIOD_NS;
  localparam int SOFT_START_CYC = (SOFT_START_US * NS_PER_US) / CLK_PERIOD_NS;
  localparam int TIMER_W = 16;

  // edge counter states
  localparam int STATE_W = 5;
  localparam logic [STATE_W-1:0] STATE_NONE = 5'h00;
  localparam logic [STATE_W-1:0] STATE_FIRST = 5'h01;
  localparam logic [STATE_W-1:0] STATE_MAIN_ONLY = 5'h05;
  localparam logic [STATE_W-1:0] STATE_SUB_ONLY = 5'h09;
  localparam logic [STATE_W-1:0] STATE_DIM_FIRST = 5'h0d;
  localparam logic [STATE_W-1:0] STATE_LAST = 5'h10;
  localparam logic [STATE_W-1:0] STATE_STEP = 5'h01;

  // decode fields of (state - 1)
  localparam int STEP_LSB = 0;
  localparam int GROUP_LSB = 2;
  localparam logic [1:0] GROUP_BOTH = 2'h0;
  localparam logic [1:0] GROUP_MAIN = 2'h1;
  localparam logic [1:0] GROUP_SUB = 2'h2;
  localparam logic [1:0] GROUP_DIM = 2'h3;

  typedef enum logic [3:0] {
    LVL_OFF = 4'h0,
    LVL_0MA05 = 4'h1,
    LVL_0MA5 = 4'h2,
    LVL_1MA = 4'h3,
    LVL_2MA = 4'h4,
    LVL_7MA = 4'h5,
    LVL_10MA = 4'h6,
    LVL_14MA = 4'h7,
    LVL_20MA = 4'h8
  } plcc_level_t;

  typedef enum logic [1:0] {
    PUMP_OFF = 2'h0,
    PUMP_1X = 2'h1,
    PUMP_1P5X = 2'h2,
    PUMP_2X = 2'h3
  } plcc_pump_t;

  typedef struct packed {
    plcc_level_t mainLevel;
    plcc_level_t subLevel;
    logic dimMode;
  } plcc_sink_cfg_t;

  typedef struct packed {
    logic enabled;
    logic enPrev;
    logic latched;
    logic [STATE_W-1:0] count;
    logic [STATE_W-1:0] data;
    plcc_sink_cfg_t cfg;
    plcc_pump_t pump;
    logic pumpFull;
  } plcc_ctrl_st_t;

  typedef struct packed {
    logic [TIMER_W-1:0] cnt;
  } plcc_timer_st_t;

endpackage : plcc_pkg

// File: plcc_timer.sv
// saturating cycle timer: expires after COUNT cycles of run without restart
`timescale 1ns/1ps
module plcc_timer #(
  parameter int unsigned COUNT = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic restart,
  // status
  output logic expired
);

  plcc_pkg::plcc_timer_st_t st_q;
  plcc_pkg::plcc_timer_st_t st_d;
  localparam logic [plcc_pkg::TIMER_W-1:0] LIMIT = plcc_pkg::TIMER_W'(COUNT);

  always_comb begin
    st_d = st_q;
    if (!run || restart) begin
      st_d.cnt = '0;
    end else if (st_q.cnt != LIMIT) begin
      st_d.cnt = st_q.cnt + plcc_pkg::TIMER_W'(1);
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // saturation keeps the flag up until run drops or restart is seen
  assign expired = (st_q.cnt == LIMIT);

endmodule : plcc_timer

// File: tb_top.sv
// self-checking bench for the pulse-count led current controller
`timescale 1ns/1ps
module tb_top;
  // short timeouts keep the run small
  localparam int LATCH = 30;
  localparam int OFF = 40;
  typedef struct packed {
    logic [4:0] pulses;
    plcc_pkg::plcc_sink_cfg_t cfg;
  } plcc_tb_row_t;
  // clock, reset and sensing
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic nearDropout = 1'b0;
  logic unusedSinkOpen = 1'b0;
  // host line and outputs
  logic enSet;
  logic deviceEnable;
  logic [plcc_pkg::STATE_W-1:0] latchedState;
  plcc_pkg::plcc_sink_cfg_t sinkCfg;
  plcc_pkg::plcc_pump_t pumpMode;
  logic pumpFullCapacity;
  int fail_count = 0;
  int total_checks = 0;
  plcc_tb_row_t rows[16];
  plcc_pkg::plcc_level_t hiLvl[4] = '{plcc_pkg::LVL_20MA, plcc_pkg::LVL_14MA,
    plcc_pkg::LVL_10MA, plcc_pkg::LVL_7MA};
  plcc_pkg::plcc_level_t dimLvl[4] = '{plcc_pkg::LVL_0MA05, plcc_pkg::LVL_0MA5,
    plcc_pkg::LVL_1MA, plcc_pkg::LVL_2MA};
  plcc_pkg::plcc_sink_cfg_t cfgFirst = '{plcc_pkg::LVL_20MA, plcc_pkg::LVL_20MA, 1'b0};

  always #12.5 sys_clk = ~sys_clk;

  plcc_ctrl #(.LATCH_CYCLES(LATCH), .OFF_CYCLES(OFF)) dut_u (
    .sys_clk(sys_clk),
    .rst(rst),
    .enSet(enSet),
    .nearDropout(nearDropout),
    .unusedSinkOpen(unusedSinkOpen),
    .deviceEnable(deviceEnable),
    .latchedState(latchedState),
    .sinkCfg(sinkCfg),
    .pumpMode(pumpMode),
    .pumpFullCapacity(pumpFullCapacity)
  );

  plcc_host_model host_u (
    .sys_clk(sys_clk),
    .enSet(enSet)
  );

  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results

  // sample just after the edge so its updates have landed
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : wait_cyc

  task automatic shut_down();
    host_u.drop();
    wait_cyc(OFF - 3);
    check("enabled", 9'(deviceEnable), 9'h001);
    wait_cyc(9);
    check("enabled", 9'(deviceEnable), 9'h000);
    check("state", 9'(latchedState), 9'h000);
    check("sinks", sinkCfg, 9'h000);
    check("pump", 9'(pumpMode), 9'(plcc_pkg::PUMP_OFF));
  endtask : shut_down

  initial begin
    for (int i = 0; i < 16; i++) begin
      plcc_pkg::plcc_level_t l;
      l = (i >= 12) ? dimLvl[i % 4] : hiLvl[i % 4];
      rows[i].pulses = 5'(i + 1);
      rows[i].cfg.mainLevel = (i / 4 == 2) ? plcc_pkg::LVL_OFF : l;
      rows[i].cfg.subLevel = (i / 4 == 1) ? plcc_pkg::LVL_OFF : l;
      rows[i].cfg.dimMode = (i / 4 == 3);
    end
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    wait_cyc(1);
    check("enabled", 9'(deviceEnable), 9'h000);
    check("sinks", sinkCfg, 9'h000);
    // every state from shutdown as a fast burst
    foreach (rows[i]) begin
      host_u.pulses(int'(rows[i].pulses), 1, 1);
      wait_cyc(LATCH - 6);
      check("enabled", 9'(deviceEnable), 9'h001);
      check("sinks", sinkCfg, 9'(cfgFirst));
      check("state", 9'(latchedState), 9'h001);
      check("pump", 9'(pumpMode), 9'(plcc_pkg::PUMP_1X));
      wait_cyc(12);
      check("state", 9'(latchedState), 9'(rows[i].pulses));
      check("sinks", sinkCfg, 9'(rows[i].cfg));
      shut_down();
    end
    // wrap past sixteen, then slow pulses after a latch
    host_u.pulses(18, 1, 1);
    wait_cyc(LATCH + 6);
    check("state", 9'(latchedState), 9'h002);
    host_u.pulses(3, 20, 20);
    wait_cyc(2);
    check("state", 9'(latchedState), 9'h002);
    check("sinks", sinkCfg, 9'(rows[1].cfg));
    wait_cyc(LATCH + 4);
    check("state", 9'(latchedState), 9'h003);
    check("sinks", sinkCfg, 9'(rows[2].cfg));
    // dropout steps the pump up one mode per event
    @(posedge sys_clk) nearDropout <= 1'b1;
    @(posedge sys_clk) nearDropout <= 1'b0;
    wait_cyc(2);
    check("pump", 9'(pumpMode), 9'(plcc_pkg::PUMP_1P5X));
    @(posedge sys_clk) nearDropout <= 1'b1;
    @(posedge sys_clk) nearDropout <= 1'b0;
    wait_cyc(4);
    check("pump", 9'(pumpMode), 9'(plcc_pkg::PUMP_2X));
    shut_down();
    // soft-start, long hold and open unused sink
    host_u.pulses(1, 1, 1);
    wait_cyc(plcc_pkg::SOFT_START_CYC - 20);
    check("full", 9'(pumpFullCapacity), 9'h000);
    wait_cyc(30);
    check("full", 9'(pumpFullCapacity), 9'h001);
    check("sinks", sinkCfg, 9'(cfgFirst));
    @(posedge sys_clk) unusedSinkOpen <= 1'b1;
    wait_cyc(3);
    check("pump", 9'(pumpMode), 9'(plcc_pkg::PUMP_2X));
    // reset in mid-run
    @(posedge sys_clk) rst <= 1'b1;
    host_u.drop();
    wait_cyc(2);
    check("enabled", 9'(deviceEnable), 9'h000);
    check("state", 9'(latchedState), 9'h000);
    check("pump", 9'(pumpMode), 9'(plcc_pkg::PUMP_OFF));
    check("full", 9'(pumpFullCapacity), 9'h000);
    @(posedge sys_clk) rst <= 1'b0;
    unusedSinkOpen <= 1'b0;
    wait_cyc(3);
    check("enabled", 9'(deviceEnable), 9'h000);
    results();
  end

  // the whole sequence needs well under ten thousand cycles
  initial begin
    repeat (30000) @(posedge sys_clk);
    fail_count++;
    results();
  end
endmodule : tb_top
